// ===== src/pmhc_pkg.sv
// constants and types for the loop mode, reset and holdover controller
package pmhc_pkg;
	typedef enum logic [1:0] {
		PMHC_FREERUN,
		PMHC_ACQUIRE,
		PMHC_LOCKED,
		PMHC_HOLDOVER
	} pmhc_mode_e;

	typedef enum logic [1:0] {
		PMHC_SEQ_LOAD,
		PMHC_SEQ_RUN,
		PMHC_SEQ_STORE
	} pmhc_seq_e;

	// configuration words held in the nonvolatile store
	localparam int CFG_WORDS = 6;
	localparam logic [2:0] CFG_LAST = 3'h5;
	localparam logic [2:0] CFG_IDX_LOOP = 3'h0;
	localparam logic [2:0] CFG_IDX_HOLD = 3'h1;
	localparam logic [2:0] CFG_IDX_PDIV = 3'h2;
	localparam logic [2:0] CFG_IDX_MDIV = 3'h3;
	localparam logic [2:0] CFG_IDX_NDIV = 3'h4;
	localparam logic [2:0] CFG_IDX_RDIV = 3'h5;
	localparam logic [31:0] CFG_RST = 32'h0;

	// loop word fields
	localparam int LOOP_NBW_LSB = 0;
	localparam int LOOP_FBW_LSB = 4;
	localparam int LOOP_FLEN_BIT = 8;
	localparam int LOOP_PULL_LSB = 9;
	localparam int LOOP_RAMP_LSB = 11;
	// holdover word fields
	localparam int HOLD_WIN_LSB = 0;
	localparam int HOLD_DLY_LSB = 8;
	localparam logic [2:0] HOLD_WIN_MAX = 3'h6;

	// bandwidth codes: 0 is 0.1 Hz, 15 is 4 kHz, 10 is 100 Hz
	localparam logic [3:0] NBW_CODE_MAX = 4'hf;
	localparam logic [3:0] FBW_CODE_MIN = 4'ha;

	// pull-in choices after holdover
	localparam logic [1:0] PULL_NORMAL = 2'h0;
	localparam logic [1:0] PULL_FAST = 2'h1;
	localparam logic [1:0] PULL_RAMP = 2'h2;

	// timing
	localparam longint CLK_HZ = 40_000_000;
	localparam int HIST_SPAN_S = 120;
	localparam int SAMPLE_PERIOD_MS = 1000;
	localparam int RAMP_TICK_MS = 1;
	localparam int HIST_DEPTH = HIST_SPAN_S * 1000 / SAMPLE_PERIOD_MS;
	localparam int SAMPLE_CYC = int'(CLK_HZ / 1000 * SAMPLE_PERIOD_MS);
	localparam int RAMP_TICK_CYC = int'(CLK_HZ / 1000 * RAMP_TICK_MS);

	// ramp step per ramp tick in ppt (frequency word unit is 1e-12)
	function automatic logic [31:0] ramp_step(input logic [2:0] code);
		case (code)
			3'h0: ramp_step = 32'h0000_02ee; // 0.75 ppm/s
			3'h1: ramp_step = 32'h0000_05dc;
			3'h2: ramp_step = 32'h0000_0bb8;
			3'h3: ramp_step = 32'h0000_1388;
			3'h4: ramp_step = 32'h0000_2710;
			3'h5: ramp_step = 32'h0000_4e20;
			3'h6: ramp_step = 32'h0000_7530;
			default: ramp_step = 32'h0000_9c40; // 40 ppm/s
		endcase
	endfunction
endpackage

// ===== src/pmhc_tick.sv
// periodic one-cycle enable pulse from a cycle divider
`timescale 1ns/1ps
module pmhc_tick #(
	parameter int PERIOD = 40
) (
	input wire logic mclk_i, // system clock
	input wire logic rst_i, // async reset, high
	input wire logic clr_i, // hold counter at zero
	output logic tick_o // one pulse per period
);
	localparam int CW = $clog2(PERIOD + 1);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;

	// restart on clear so the first tick lands a full period later
	always_comb begin
		tick_o = 1'b0;
		nxt_cnt = cnt_ff + 1'b1;
		if (clr_i) begin
			nxt_cnt = '0;
		end else if (cnt_ff == CW'(PERIOD - 1)) begin
			nxt_cnt = '0;
			tick_o = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

// ===== src/pmhc_hist_mem.sv
// frequency history memory, one write port, registered read
`timescale 1ns/1ps
module pmhc_hist_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 120
) (
	input wire logic mclk_i, // system clock
	input wire logic wr_en_i, // write strobe
	input wire logic [$clog2(DEPTH)-1:0] wr_addr_i, // write address
	input wire logic [WIDTH-1:0] wr_data_i, // write data
	input wire logic [$clog2(DEPTH)-1:0] rd_addr_i, // read address
	output logic [WIDTH-1:0] rd_data_o // read data, one cycle later
);
	logic [WIDTH-1:0] mem [DEPTH];

	// no reset: contents are only read below the fill count
	always_ff @(posedge mclk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule

// ===== src/pmhc_ctrl.sv
// loop mode, reset sequencing and holdover averaging controller
`timescale 1ns/1ps
module pmhc_ctrl #(
	parameter int SAMPLE_CYC = pmhc_pkg::SAMPLE_CYC,
	parameter int RAMP_TICK_CYC = pmhc_pkg::RAMP_TICK_CYC,
	parameter int HIST_DEPTH = pmhc_pkg::HIST_DEPTH
) (
	input wire logic mclk_i, // 40 MHz clock
	input wire logic rst_i, // power-up reset, async high
	input wire logic rst_pin_n_i, // external reset pin, low
	input wire logic hard_reset_bit_i, // software hard reset
	input wire logic soft_reset_i, // apply written configuration
	input wire logic store_req_i, // save configuration to store
	input wire logic host_wr_i, // host config write strobe
	input wire logic [2:0] host_idx_i, // config word index
	input wire logic [31:0] host_data_i, // config word data
	output logic nvm_rd_o, // store read strobe
	output logic nvm_wr_o, // store write strobe
	output logic [2:0] nvm_addr_o, // store word address
	output logic [31:0] nvm_wdata_o, // store write data
	input wire logic [31:0] nvm_rdata_i, // store data, 1 cycle after read
	input wire logic any_valid_i, // some input clock valid
	input wire logic sel_valid_i, // selected input clock valid
	input wire logic lock_det_i, // phase detector reports lock
	input wire logic [31:0] loop_freq_i, // loop frequency offset, ppt
	input wire logic [31:0] in_freq_i, // input frequency offset, ppt
	output logic serial_ready_o, // serial port accepts traffic
	output logic clk_out_en_o, // output clocks enabled
	output logic [1:0] mode_o, // loop mode status code
	output logic loss_of_lock_flag_o, // loss-of-lock pin, high
	output logic lol_status_o, // loss-of-lock status bit
	output logic [3:0] loop_bw_o, // active bandwidth code
	output logic freq_ovr_o, // loop steered by freq_word_o
	output logic [31:0] freq_word_o, // steering frequency offset
	output logic [31:0] pdiv_o, // input divider ratio
	output logic [31:0] mdiv_o, // feedback divider ratio
	output logic [31:0] ndiv_o, // output divider ratio
	output logic [31:0] rdiv_o // integer output divider
);
	localparam int AW = $clog2(HIST_DEPTH);
	localparam int AVG_MAX = 200;

	logic hard_req;
	pmhc_pkg::pmhc_seq_e seq_ff, nxt_seq;
	logic [2:0] ld_idx_ff, nxt_ld_idx, rd_idx_ff, nxt_rd_idx;
	logic rd_pend_ff, nxt_rd_pend;
	logic [31:0] act_ff [pmhc_pkg::CFG_WORDS];
	logic [31:0] nxt_act [pmhc_pkg::CFG_WORDS];
	logic [31:0] shd_ff [pmhc_pkg::CFG_WORDS];
	logic [31:0] nxt_shd [pmhc_pkg::CFG_WORDS];
	logic running;

	assign hard_req = ~rst_pin_n_i | hard_reset_bit_i;
	assign running = (seq_ff != pmhc_pkg::PMHC_SEQ_LOAD);

	// load, soft apply and store sequencing of the configuration words
	always_comb begin
		nxt_seq = seq_ff;
		nxt_ld_idx = ld_idx_ff;
		nxt_rd_idx = rd_idx_ff;
		nxt_rd_pend = 1'b0;
		nxt_act = act_ff;
		nxt_shd = shd_ff;
		nvm_rd_o = 1'b0;
		nvm_wr_o = 1'b0;
		if (hard_req) begin
			nxt_seq = pmhc_pkg::PMHC_SEQ_LOAD;
			nxt_ld_idx = 3'h0;
			for (int i = 0; i < pmhc_pkg::CFG_WORDS; i++) begin
				nxt_act[i] = pmhc_pkg::CFG_RST;
				nxt_shd[i] = pmhc_pkg::CFG_RST;
			end
		end else begin
			case (seq_ff)
				pmhc_pkg::PMHC_SEQ_LOAD: begin
					if (ld_idx_ff <= pmhc_pkg::CFG_LAST) begin
						nvm_rd_o = 1'b1;
						nxt_rd_pend = 1'b1;
						nxt_rd_idx = ld_idx_ff;
						nxt_ld_idx = ld_idx_ff + 3'h1;
					end
					if (rd_pend_ff) begin
						nxt_act[rd_idx_ff] = nvm_rdata_i;
						nxt_shd[rd_idx_ff] = nvm_rdata_i;
						if (rd_idx_ff == pmhc_pkg::CFG_LAST) begin
							nxt_seq = pmhc_pkg::PMHC_SEQ_RUN;
						end
					end
				end
				pmhc_pkg::PMHC_SEQ_STORE: begin
					nvm_wr_o = 1'b1;
					nxt_ld_idx = ld_idx_ff + 3'h1;
					if (ld_idx_ff == pmhc_pkg::CFG_LAST) begin
						nxt_seq = pmhc_pkg::PMHC_SEQ_RUN;
					end
				end
				default: begin
					if (soft_reset_i) begin
						nxt_act = shd_ff;
					end else if (store_req_i) begin
						nxt_seq = pmhc_pkg::PMHC_SEQ_STORE;
						nxt_ld_idx = 3'h0;
					end
				end
			endcase
			// host writes land in the shadow only, never mid-load
			if (running && host_wr_i &&
					host_idx_i <= pmhc_pkg::CFG_LAST) begin
				nxt_shd[host_idx_i] = host_data_i;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			seq_ff <= pmhc_pkg::PMHC_SEQ_LOAD;
			ld_idx_ff <= 3'h0;
			rd_idx_ff <= 3'h0;
			rd_pend_ff <= 1'b0;
			for (int i = 0; i < pmhc_pkg::CFG_WORDS; i++) begin
				act_ff[i] <= pmhc_pkg::CFG_RST;
				shd_ff[i] <= pmhc_pkg::CFG_RST;
			end
		end else begin
			seq_ff <= nxt_seq;
			ld_idx_ff <= nxt_ld_idx;
			rd_idx_ff <= nxt_rd_idx;
			rd_pend_ff <= nxt_rd_pend;
			act_ff <= nxt_act;
			shd_ff <= nxt_shd;
		end
	end

	assign nvm_addr_o = ld_idx_ff;
	// index parks one past the last word once idle; never read outside
	assign nvm_wdata_o = (ld_idx_ff <= pmhc_pkg::CFG_LAST)
		? act_ff[ld_idx_ff] : pmhc_pkg::CFG_RST;
	assign serial_ready_o = running;
	assign clk_out_en_o = running;
	assign pdiv_o = act_ff[pmhc_pkg::CFG_IDX_PDIV];
	assign mdiv_o = act_ff[pmhc_pkg::CFG_IDX_MDIV];
	assign ndiv_o = act_ff[pmhc_pkg::CFG_IDX_NDIV];
	assign rdiv_o = act_ff[pmhc_pkg::CFG_IDX_RDIV];

	// configuration fields
	logic [31:0] loop_w, hold_w;
	logic [3:0] nbw, fbw;
	logic flen;
	logic [1:0] pull;
	logic [2:0] ramp_code, win;
	logic [6:0] dly;
	assign loop_w = act_ff[pmhc_pkg::CFG_IDX_LOOP];
	assign hold_w = act_ff[pmhc_pkg::CFG_IDX_HOLD];
	assign nbw = loop_w[pmhc_pkg::LOOP_NBW_LSB +: 4];
	// fast codes below 100 Hz are raised to the 100 Hz floor
	assign fbw = (loop_w[pmhc_pkg::LOOP_FBW_LSB +: 4] < pmhc_pkg::FBW_CODE_MIN)
		? pmhc_pkg::FBW_CODE_MIN : loop_w[pmhc_pkg::LOOP_FBW_LSB +: 4];
	assign flen = loop_w[pmhc_pkg::LOOP_FLEN_BIT];
	assign pull = loop_w[pmhc_pkg::LOOP_PULL_LSB +: 2];
	assign ramp_code = loop_w[pmhc_pkg::LOOP_RAMP_LSB +: 3];
	assign win = hold_w[pmhc_pkg::HOLD_WIN_LSB +: 3];
	assign dly = hold_w[pmhc_pkg::HOLD_DLY_LSB +: 7];

	// history store and averaging state
	logic samp_tick, ramp_tick;
	logic [AW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
	logic [AW:0] hcnt_ff, nxt_hcnt;
	logic avg_busy_ff, nxt_avg_busy, avg_pend_ff, nxt_avg_pend;
	logic [6:0] avg_left_ff, nxt_avg_left;
	logic [2:0] avg_k_ff, nxt_avg_k;
	logic signed [39:0] acc_ff, nxt_acc;
	logic [31:0] hist_rd;
	logic [AW:0] d_eff, avail;
	logic [2:0] k_sel;
	logic signed [AW+1:0] start_a;

	pmhc_pkg::pmhc_mode_e mode_ff, nxt_mode;
	logic ramp_ff, nxt_ramp, pfast_ff, nxt_pfast;
	logic [31:0] word_ff, nxt_word;

	pmhc_tick #(.PERIOD(SAMPLE_CYC)) u_samp (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.clr_i(mode_ff != pmhc_pkg::PMHC_LOCKED),
		.tick_o(samp_tick)
	);

	pmhc_tick #(.PERIOD(RAMP_TICK_CYC)) u_ramp (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.clr_i(!ramp_ff),
		.tick_o(ramp_tick)
	);

	pmhc_hist_mem #(.WIDTH(32), .DEPTH(HIST_DEPTH)) u_hist (
		.mclk_i(mclk_i),
		.wr_en_i(samp_tick),
		.wr_addr_i(wptr_ff),
		.wr_data_i(loop_freq_i),
		.rd_addr_i(rptr_ff),
		.rd_data_o(hist_rd)
	);

	// effective delay and window so the window never runs past the history
	always_comb begin
		d_eff = '0;
		if (hcnt_ff != '0) begin
			d_eff = ((AW+1)'(dly) < hcnt_ff) ? (AW+1)'(dly) : hcnt_ff - 1'b1;
		end
		avail = hcnt_ff - d_eff;
		k_sel = 3'h0;
		for (int j = 0; j <= 6; j++) begin
			if (3'(j) <= win && (AW+2)'(1 << j) <= (AW+2)'(avail)) begin
				k_sel = 3'(j);
			end
		end
		start_a = (AW+2)'(wptr_ff) - (AW+2)'(1) - (AW+2)'(d_eff);
		if (start_a < 0) begin
			start_a = start_a + (AW+2)'(HIST_DEPTH);
		end
	end

	// history writes while locked, and the window sum on entry to holdover from locked
	always_comb begin
		nxt_wptr = wptr_ff;
		nxt_hcnt = hcnt_ff;
		nxt_rptr = rptr_ff;
		nxt_avg_busy = avg_busy_ff;
		nxt_avg_pend = 1'b0;
		nxt_avg_left = avg_left_ff;
		nxt_avg_k = avg_k_ff;
		nxt_acc = acc_ff;
		if (hard_req) begin
			nxt_wptr = '0;
			nxt_hcnt = '0;
			nxt_avg_busy = 1'b0;
		end else begin
			if (samp_tick) begin
				nxt_wptr = (wptr_ff == AW'(HIST_DEPTH - 1)) ? '0 : wptr_ff + 1'b1;
				if (hcnt_ff != (AW+1)'(HIST_DEPTH)) begin
					nxt_hcnt = hcnt_ff + 1'b1;
				end
			end
			// same entry condition as the mode machine, kept local so the
			// two next-state processes do not read each other
			if (mode_ff == pmhc_pkg::PMHC_LOCKED && running &&
					!sel_valid_i && !any_valid_i && hcnt_ff != '0) begin
				nxt_avg_busy = 1'b1;
				nxt_avg_k = k_sel;
				nxt_avg_left = 7'(1 << k_sel);
				nxt_rptr = AW'(start_a); // newest sample after the delay
				nxt_acc = '0;
			end else if (avg_busy_ff) begin
				if (avg_left_ff != 7'h0) begin
					nxt_avg_pend = 1'b1;
					nxt_avg_left = avg_left_ff - 7'h1;
					nxt_rptr = (rptr_ff == '0) ? AW'(HIST_DEPTH - 1) : rptr_ff - 1'b1;
				end
				if (avg_pend_ff) begin
					nxt_acc = acc_ff + 40'(signed'(hist_rd));
				end
				if (avg_left_ff == 7'h0 && !avg_pend_ff) begin
					nxt_avg_busy = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wptr_ff <= '0;
			hcnt_ff <= '0;
			rptr_ff <= '0;
			avg_busy_ff <= 1'b0;
			avg_pend_ff <= 1'b0;
			avg_left_ff <= 7'h0;
			avg_k_ff <= 3'h0;
			acc_ff <= '0;
		end else begin
			wptr_ff <= nxt_wptr;
			hcnt_ff <= nxt_hcnt;
			rptr_ff <= nxt_rptr;
			avg_busy_ff <= nxt_avg_busy;
			avg_pend_ff <= nxt_avg_pend;
			avg_left_ff <= nxt_avg_left;
			avg_k_ff <= nxt_avg_k;
			acc_ff <= nxt_acc;
		end
	end

	// loop mode machine with holdover steering and ramped pull-in
	logic [31:0] step, diff;
	logic signed [39:0] avg_val;
	assign step = pmhc_pkg::ramp_step(ramp_code);
	assign diff = in_freq_i - word_ff;
	assign avg_val = acc_ff >>> avg_k_ff;

	always_comb begin
		nxt_mode = mode_ff;
		nxt_ramp = ramp_ff;
		nxt_pfast = pfast_ff;
		nxt_word = word_ff;
		if (hard_req || !running) begin
			nxt_mode = pmhc_pkg::PMHC_FREERUN;
			nxt_ramp = 1'b0;
			nxt_pfast = 1'b0;
			nxt_word = '0;
		end else begin
			case (mode_ff)
				pmhc_pkg::PMHC_FREERUN: begin
					nxt_word = '0; // nominal: tracks the reference oscillator
					if (any_valid_i) begin
						nxt_mode = pmhc_pkg::PMHC_ACQUIRE;
						nxt_pfast = flen;
					end
				end
				pmhc_pkg::PMHC_ACQUIRE: begin
					if (!any_valid_i) begin
						nxt_mode = (hcnt_ff != '0) ? pmhc_pkg::PMHC_HOLDOVER
							: pmhc_pkg::PMHC_FREERUN;
						nxt_ramp = 1'b0;
					end else if (ramp_ff) begin
						if (ramp_tick) begin
							// step toward the input, landing exactly on it
							if ($signed(diff) > $signed(step)) begin
								nxt_word = word_ff + step;
							end else if ($signed(diff) < -$signed(step)) begin
								nxt_word = word_ff - step;
							end else begin
								nxt_word = in_freq_i;
								nxt_ramp = 1'b0;
							end
						end
					end else if (lock_det_i) begin
						nxt_mode = pmhc_pkg::PMHC_LOCKED;
					end
				end
				pmhc_pkg::PMHC_LOCKED: begin
					nxt_word = loop_freq_i;
					if (!sel_valid_i && !any_valid_i) begin
						nxt_mode = (hcnt_ff != '0) ? pmhc_pkg::PMHC_HOLDOVER
							: pmhc_pkg::PMHC_FREERUN;
					end else if (!sel_valid_i) begin
						nxt_mode = pmhc_pkg::PMHC_ACQUIRE;
						nxt_pfast = flen;
					end
				end
				default: begin
					if (avg_busy_ff && avg_left_ff == 7'h0 &&
							!avg_pend_ff) begin
						nxt_word = 32'(avg_val);
					end
					if (any_valid_i && !avg_busy_ff) begin
						nxt_mode = pmhc_pkg::PMHC_ACQUIRE;
						nxt_ramp = (pull == pmhc_pkg::PULL_RAMP);
						nxt_pfast = (pull == pmhc_pkg::PULL_FAST);
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_ff <= pmhc_pkg::PMHC_FREERUN;
			ramp_ff <= 1'b0;
			pfast_ff <= 1'b0;
			word_ff <= '0;
		end else begin
			mode_ff <= nxt_mode;
			ramp_ff <= nxt_ramp;
			pfast_ff <= nxt_pfast;
			word_ff <= nxt_word;
		end
	end

	assign mode_o = mode_ff;
	assign loss_of_lock_flag_o = (mode_ff != pmhc_pkg::PMHC_LOCKED);
	assign lol_status_o = (mode_ff != pmhc_pkg::PMHC_LOCKED);
	assign loop_bw_o = (mode_ff == pmhc_pkg::PMHC_ACQUIRE && pfast_ff)
		? fbw : nbw;
	assign freq_ovr_o = (mode_ff == pmhc_pkg::PMHC_FREERUN) ||
		(mode_ff == pmhc_pkg::PMHC_HOLDOVER) || ramp_ff;
	assign freq_word_o = word_ff;

	logic host_wr_ok;
	assign host_wr_ok = running && host_wr_i;
	chk_port_closed: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_ff == pmhc_pkg::PMHC_SEQ_LOAD |-> !serial_ready_o && !host_wr_ok)
		else $error("serial port open during load");
	chk_clk_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		!serial_ready_o |-> !clk_out_en_o && mode_o == 2'h0)
		else $error("clocks enabled before initialization");
	chk_hard_reload: assert property (@(posedge mclk_i) disable iff (rst_i)
		hard_req |=> seq_ff == pmhc_pkg::PMHC_SEQ_LOAD && ld_idx_ff == 3'h0
		&& !serial_ready_o)
		else $error("hard reset did not restart load");
	chk_soft_apply: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_ff == pmhc_pkg::PMHC_SEQ_RUN && soft_reset_i && !hard_req
		|=> !nvm_rd_o && pdiv_o == $past(shd_ff[pmhc_pkg::CFG_IDX_PDIV]))
		else $error("soft reset did not apply shadow");
	chk_acq_start: assert property (@(posedge mclk_i) disable iff (rst_i)
		running && mode_ff == pmhc_pkg::PMHC_FREERUN && any_valid_i
		&& !hard_req |=> mode_ff == pmhc_pkg::PMHC_ACQUIRE)
		else $error("acquisition not started");
	chk_bw_sel: assert property (@(posedge mclk_i) disable iff (rst_i)
		mode_ff == pmhc_pkg::PMHC_LOCKED |-> loop_bw_o == nbw)
		else $error("locked loop not on normal bandwidth");
	chk_lol_match: assert property (@(posedge mclk_i) disable iff (rst_i)
		loss_of_lock_flag_o == lol_status_o
		&& (loss_of_lock_flag_o == (mode_o != 2'h2)))
		else $error("loss-of-lock pin and bit differ");
	chk_hold_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
		mode_ff == pmhc_pkg::PMHC_LOCKED && !sel_valid_i && !any_valid_i
		&& hcnt_ff != '0 && !hard_req |=> mode_ff == pmhc_pkg::PMHC_HOLDOVER
		##0 avg_busy_ff)
		else $error("holdover not entered");
	chk_avg_done: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(avg_busy_ff) |-> ##[1:AVG_MAX] !avg_busy_ff)
		else $error("holdover average too slow");
	chk_ramp_step: assert property (@(posedge mclk_i) disable iff (rst_i)
		ramp_ff && !ramp_tick && !hard_req |=> $stable(freq_word_o))
		else $error("ramp moved without a tick");
	cov_locked: cover property (@(posedge mclk_i) disable iff (rst_i)
		$rose(mode_ff == pmhc_pkg::PMHC_LOCKED));
	cov_holdover: cover property (@(posedge mclk_i) disable iff (rst_i)
		$fell(avg_busy_ff) && mode_ff == pmhc_pkg::PMHC_HOLDOVER);
	cov_ramp: cover property (@(posedge mclk_i) disable iff (rst_i)
		$fell(ramp_ff) && any_valid_i);
endmodule

// ===== bench/pmhc_store_model.sv
// behavioural nonvolatile store facing the controller's load and save port
`timescale 1ns/1ps
module pmhc_store_model (
	input wire logic mclk_i, // system clock
	input wire logic rd_i, // read strobe
	input wire logic wr_i, // write strobe
	input wire logic [2:0] addr_i, // word address
	input wire logic [31:0] wdata_i, // write data
	output logic [31:0] rdata_o // data one cycle after read
);
	logic [31:0] mem [0:5];
	// stored defaults: fast lock on, window 4, delay 1, distinct dividers
	initial begin
		mem[0] = 32'h0000_01c3;
		mem[1] = 32'h0000_0102;
		mem[2] = 32'h0000_0011;
		mem[3] = 32'h0000_0022;
		mem[4] = 32'h0000_0033;
		mem[5] = 32'h0000_0044;
		rdata_o = 32'h0;
	end
	// data toggles when not read so a late capture never sees a stale word
	always @(posedge mclk_i) begin
		if (rd_i && addr_i < 3'h6) rdata_o <= mem[addr_i];
		else rdata_o <= ~rdata_o;
		if (wr_i && addr_i < 3'h6) mem[addr_i] <= wdata_i;
	end
endmodule

// ===== bench/tb_pmhc_ctrl.sv
// self-checking bench for the loop mode, reset and holdover controller
`timescale 1ns/1ps
module tb_pmhc_ctrl;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic rst_pin_n_i = 1'b1;
	logic hard_reset_bit_i = 1'b0;
	logic soft_reset_i = 1'b0;
	logic store_req_i = 1'b0;
	logic host_wr_i = 1'b0;
	logic [2:0] host_idx_i = 3'h0;
	logic [31:0] host_data_i = 32'h0;
	logic any_valid_i = 1'b0;
	logic sel_valid_i = 1'b0;
	logic lock_det_i = 1'b0;
	logic [31:0] loop_freq_i = 32'h0000_1000;
	logic [31:0] in_freq_i = 32'h0;
	logic nvm_rd_o, nvm_wr_o, serial_ready_o, clk_out_en_o, freq_ovr_o;
	logic loss_of_lock_flag_o, lol_status_o;
	logic [2:0] nvm_addr_o;
	logic [31:0] nvm_wdata_o, nvm_rdata_i, freq_word_o;
	logic [31:0] pdiv_o, mdiv_o, ndiv_o, rdiv_o;
	logic [1:0] mode_o;
	logic [3:0] loop_bw_o;
	int miscompares = 0;
	int check_count = 0;

	// 40 MHz clock
	always #12.5 mclk_i = ~mclk_i;

	// short sample and ramp periods keep the run brief
	pmhc_ctrl #(.SAMPLE_CYC(16), .RAMP_TICK_CYC(4)) pmhc_ctrl_i (
		.mclk_i(mclk_i), .rst_i(rst_i), .rst_pin_n_i(rst_pin_n_i),
		.hard_reset_bit_i(hard_reset_bit_i), .soft_reset_i(soft_reset_i),
		.store_req_i(store_req_i), .host_wr_i(host_wr_i),
		.host_idx_i(host_idx_i), .host_data_i(host_data_i),
		.nvm_rd_o(nvm_rd_o), .nvm_wr_o(nvm_wr_o), .nvm_addr_o(nvm_addr_o),
		.nvm_wdata_o(nvm_wdata_o), .nvm_rdata_i(nvm_rdata_i),
		.any_valid_i(any_valid_i), .sel_valid_i(sel_valid_i),
		.lock_det_i(lock_det_i), .loop_freq_i(loop_freq_i),
		.in_freq_i(in_freq_i), .serial_ready_o(serial_ready_o),
		.clk_out_en_o(clk_out_en_o), .mode_o(mode_o),
		.loss_of_lock_flag_o(loss_of_lock_flag_o),
		.lol_status_o(lol_status_o), .loop_bw_o(loop_bw_o),
		.freq_ovr_o(freq_ovr_o), .freq_word_o(freq_word_o),
		.pdiv_o(pdiv_o), .mdiv_o(mdiv_o), .ndiv_o(ndiv_o), .rdiv_o(rdiv_o)
	);

	pmhc_store_model pmhc_store_model_i (
		.mclk_i(mclk_i), .rd_i(nvm_rd_o), .wr_i(nvm_wr_o),
		.addr_i(nvm_addr_o), .wdata_i(nvm_wdata_o), .rdata_o(nvm_rdata_i)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	// bounded wait for a mode; running out shows as a mismatch
	task automatic wait_mode(input logic [1:0] m, input int lim);
		int i;
		i = 0;
		while (mode_o !== m && i < lim) begin
			cyc(1);
			i++;
		end
		chk({30'h0, mode_o}, {30'h0, m});
	endtask

	// load in progress keeps port and clocks off, then both come up
	task automatic wait_ready();
		int i;
		i = 0;
		cyc(3);
		chk({serial_ready_o, clk_out_en_o}, 32'h0);
		while (serial_ready_o !== 1'b1 && i < 8) begin
			cyc(1);
			i++;
		end
		chk({serial_ready_o, clk_out_en_o}, 32'h3);
		chk({30'h0, mode_o}, 32'h0);
		chk({pdiv_o[7:0], mdiv_o[7:0], ndiv_o[7:0], rdiv_o[7:0]},
			32'h1122_3344);
	endtask

	task automatic host_write(input logic [2:0] idx, input logic [31:0] d);
		@(posedge mclk_i);
		host_wr_i <= 1'b1;
		host_idx_i <= idx;
		host_data_i <= d;
		@(posedge mclk_i);
		host_wr_i <= 1'b0;
	endtask

	task automatic hard_rst(input logic by_pin);
		@(posedge mclk_i);
		if (by_pin) rst_pin_n_i <= 1'b0;
		else hard_reset_bit_i <= 1'b1;
		@(posedge mclk_i);
		rst_pin_n_i <= 1'b1;
		hard_reset_bit_i <= 1'b0;
		wait_ready();
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		wait_ready();
		chk({freq_ovr_o, loss_of_lock_flag_o, lol_status_o}, 32'h7);
		host_write(3'h2, 32'h55);
		cyc(1);
		chk(pdiv_o, 32'h11);
		@(posedge mclk_i);
		soft_reset_i <= 1'b1;
		@(posedge mclk_i);
		soft_reset_i <= 1'b0;
		cyc(2);
		chk(pdiv_o, 32'h55);
		chk({30'h0, serial_ready_o}, 32'h1);
		@(posedge mclk_i);
		store_req_i <= 1'b1;
		@(posedge mclk_i);
		store_req_i <= 1'b0;
		cyc(10);
		chk(pmhc_store_model_i.mem[2], 32'h55);
		pmhc_store_model_i.mem[2] = 32'h11;
		host_write(3'h2, 32'h66);
		hard_rst(1'b1);
		host_write(3'h2, 32'h77);
		hard_rst(1'b0);
		@(posedge mclk_i);
		any_valid_i <= 1'b1;
		sel_valid_i <= 1'b1;
		wait_mode(2'h1, 4);
		chk({loop_bw_o, loss_of_lock_flag_o, lol_status_o}, 32'h33);
		chk({31'h0, clk_out_en_o}, 32'h1);
		@(posedge mclk_i);
		lock_det_i <= 1'b1;
		wait_mode(2'h2, 4);
		chk({loop_bw_o, loss_of_lock_flag_o, lol_status_o}, 32'hc);
		cyc(192);
		any_valid_i <= 1'b0;
		sel_valid_i <= 1'b0;
		lock_det_i <= 1'b0;
		wait_mode(2'h3, 6);
		cyc(80);
		chk(freq_word_o, 32'h0000_1000);
		chk({31'h0, freq_ovr_o}, 32'h1);
		any_valid_i <= 1'b1;
		sel_valid_i <= 1'b1;
		wait_mode(2'h1, 8);
		chk({31'h0, loss_of_lock_flag_o}, 32'h1);
		lock_det_i <= 1'b1;
		wait_mode(2'h2, 8);
		// ramp pull-in: 0.75 ppm/s code, two steps then land on target
		host_write(3'h0, 32'h553);
		@(posedge mclk_i);
		soft_reset_i <= 1'b1;
		@(posedge mclk_i);
		soft_reset_i <= 1'b0;
		cyc(2);
		any_valid_i <= 1'b0;
		sel_valid_i <= 1'b0;
		lock_det_i <= 1'b0;
		wait_mode(2'h3, 6);
		cyc(20);
		chk(freq_word_o, 32'h0000_1000);
		in_freq_i <= 32'h0000_18ca;
		any_valid_i <= 1'b1;
		sel_valid_i <= 1'b1;
		wait_mode(2'h1, 8);
		chk({loop_bw_o, freq_ovr_o}, 32'h7);
		cyc(6);
		chk(freq_word_o, 32'h0000_12ee);
		cyc(20);
		chk(freq_word_o, 32'h0000_18ca);
		chk({30'h0, mode_o}, 32'h1);
		lock_det_i <= 1'b1;
		wait_mode(2'h2, 8);
		results();
	end

	// watchdog: the whole sequence needs well under 1000 cycles
	initial begin
		#100000;
		miscompares++;
		results();
	end
endmodule
